// *** src/vmc_pkg.sv ***
package vmc_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned REG_W         = 8;
  localparam int unsigned LVL_W         = 2;

  // Register byte offsets
  localparam logic [7:0]  OFF_OTG_CTRL  = 8'h00;
  localparam logic [7:0]  OFF_EN_RISE   = 8'h04;
  localparam logic [7:0]  OFF_EN_FALL   = 8'h08;
  localparam logic [7:0]  OFF_INT_STAT  = 8'h0C;
  localparam logic [7:0]  OFF_EXT_CFG   = 8'h10;
  localparam logic [7:0]  OFF_IO_PWR    = 8'h14;
  localparam logic [7:0]  OFF_IRQ_STAT  = 8'h18;
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'h1C;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  // Comparator bits, shared by both enable registers and the status register
  localparam int unsigned VBUS_BIT      = 1;
  localparam int unsigned SESS_BIT      = 2;

  // Control register
  localparam int unsigned DISCHARGE_BIT = 3;
  localparam int unsigned CHARGE_BIT    = 4;

  // External indicator configuration
  localparam int unsigned EXT_USE_BIT   = 0;
  localparam int unsigned EXT_PASS_BIT  = 1;
  localparam int unsigned EXT_COMPL_BIT = 2;

  // IO and power management register
  localparam int unsigned UART_MODE_BIT = 0;
  localparam int unsigned DP_PU_BIT     = 1;
  localparam int unsigned DM_PU_BIT     = 2;
  localparam int unsigned UART_LVL_LO   = 3;
  localparam int unsigned UART_LVL_HI   = 4;
  localparam int unsigned NORM_LVL_LO   = 5;
  localparam int unsigned NORM_LVL_HI   = 6;

  // Interrupt status and mask bits
  localparam int unsigned IRQ_W         = 4;
  localparam int unsigned IRQ_VBUS_RISE = 0;
  localparam int unsigned IRQ_VBUS_FALL = 1;
  localparam int unsigned IRQ_SESS_RISE = 2;
  localparam int unsigned IRQ_SESS_FALL = 3;

  // Reset values
  localparam logic [7:0]  RST_OTG_CTRL  = 8'h00;
  localparam logic [7:0]  RST_INT_EN    = 8'h06;
  localparam logic [7:0]  RST_EXT_CFG   = 8'h00;
  localparam logic [7:0]  RST_IO_PWR    = 8'h00;
  localparam logic [7:0]  RST_IRQ_MASK  = 8'h00;

endpackage : vmc_pkg

// *** src/vmc_vbus_select.sv ***
`timescale 1ns/10ps
module vmc_vbus_select
  import vmc_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // Selection controls
  input  wire logic use_ext_i,
  input  wire logic pass_i,
  input  wire logic compl_i,
  input  wire logic cmp_i,
  // Selected source
  output logic      sel_o,
  output logic      changed_o
);

  // No pin carries the external indicator, so it is a constant high
  localparam logic EXT_IND = 1'b1; // see RULE_02

  typedef struct packed {
    logic sel;
    logic changed;
  } vmc_sel_state_t;

  vmc_sel_state_t s;
  vmc_sel_state_t s_nxt;
  logic           ind;

  always_comb begin
    s_nxt = s;
    ind   = compl_i ? ~EXT_IND : EXT_IND;
    if (!use_ext_i) begin
      s_nxt.sel = cmp_i; // see RULE_04
    end else if (pass_i) begin
      s_nxt.sel = ind; // see RULE_05
    end else begin
      s_nxt.sel = ind & cmp_i; // see RULE_06
    end
    s_nxt.changed = s_nxt.sel ^ s.sel;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= s_nxt;
    end
  end

  assign sel_o     = s.sel;
  assign changed_o = s.changed;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  internal_path_a: assert property (!use_ext_i |=> sel_o == $past(cmp_i)) // see RULE_04
    else $error("internal comparator not selected");
  fixed_states_a: assert property (use_ext_i && compl_i |=> !sel_o) // see RULE_05
    else $error("complemented indicator not fixed low");
  fixed_high_a: assert property (use_ext_i && pass_i && !compl_i |=> sel_o) // see RULE_05
    else $error("pass-through indicator not fixed high");
  gated_path_a: assert property (use_ext_i && !pass_i && !compl_i |=> sel_o == $past(cmp_i)) // see RULE_06
    else $error("gated indicator does not follow comparator");

endmodule : vmc_vbus_select

// *** src/vmc_vbus_monitor.sv ***
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
// What this block does
// RULE_01: Clearing the VBUS-valid enable in both edge enable registers turns the comparator off and status bit 1 reads 0.
// RULE_02: The external VBUS-valid indicator is a constant one inside the device.
// RULE_03: After reset the external indicator path is off, so the internal comparator is reported.
// RULE_04: With external select at 0 the reported VBUS-valid is the internal comparator.
// RULE_05: With external select at 1 the report is fixed 1 for pass-through without complement, fixed 0 with complement.
// RULE_06: With external select at 1 and both pass-through and complement at 0 the report follows the comparator.
// RULE_07: A plain peripheral link should start from session-valid, not from VBUS-valid.
// RULE_08: Control bit 3 switches the VBUS discharge resistor to ground.
// RULE_09: Control bit 4 switches the VBUS charge pull-up resistor.
// RULE_10: In UART mode the regulator output takes the UART regulator level field.
// RULE_11: In UART mode the line state is not presented on data bits 0 and 1.
// RULE_12: With the chip reset low both detection pull-ups are off, otherwise each follows its enable bit.
// RULE_13: Clearing both session-valid enables only stops its interrupts; its state stays readable.
// RULE_14: A change of the selected VBUS-valid source is reported to the link in the next receive command.
module vmc_vbus_monitor
  import vmc_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [DATA_W-1:0] s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [DATA_W-1:0]      s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // Analogue comparators and pins
  input  wire logic              vbus_valid_cmp_i,
  input  wire logic              session_valid_cmp_i,
  input  wire logic              chip_reset_n_i,
  input  wire logic [1:0]        linestate_i,
  // Analogue controls
  output logic                   vbus_cmp_en_o,
  output logic                   vbus_discharge_ctl_o,
  output logic                   vbus_charge_ctl_o,
  output logic                   dp_detect_pullup_o,
  output logic                   dm_detect_pullup_o,
  output logic [LVL_W-1:0]       regulator_level_o,
  // Receive command side
  output logic [1:0]             ulpi_data_lo_o,
  output logic                   rxcmd_vbus_valid_o,
  output logic                   rxcmd_req_o,
  input  wire logic              rxcmd_ack_i,
  // Interrupt
  output logic                   irq_o
);

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [DATA_W-1:0] rdata;
    logic [REG_W-1:0]  otg_ctrl;
    logic [REG_W-1:0]  en_rise;
    logic [REG_W-1:0]  en_fall;
    logic [REG_W-1:0]  ext_cfg;
    logic [REG_W-1:0]  io_pwr;
    logic [REG_W-1:0]  irq_mask;
    logic [IRQ_W-1:0]  irq_stat;
    logic              vbus_prev;
    logic              sess_prev;
    logic              irq;
    logic              rxcmd_pend;
    logic              rxcmd_vbus;
    logic              cmp_en;
    logic              discharge;
    logic              charge;
    logic              dp_pu;
    logic              dm_pu;
    logic [LVL_W-1:0]  reg_level;
    logic [1:0]        data_lo;
  } vmc_state_t;

  vmc_state_t s;
  vmc_state_t s_nxt;

  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic do_wr;
  logic cmp_en;
  logic vbus_gated;
  logic sel_vbus;
  logic sel_changed;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    unique case (addr)
      OFF_OTG_CTRL, OFF_EN_RISE, OFF_EN_FALL, OFF_INT_STAT,
      OFF_EXT_CFG, OFF_IO_PWR, OFF_IRQ_STAT, OFF_IRQ_MASK: is_mapped = 1'b1;
      default:                                             is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  assign aw_fire = s_axi_awvalid_i & s.awready;
  assign w_fire  = s_axi_wvalid_i & s.wready;
  assign ar_fire = s_axi_arvalid_i & s.arready;
  assign do_wr   = s.aw_held & s.w_held & ~s.bvalid;

  // Comparator runs while either edge enable holds its bit
  assign cmp_en     = s.en_rise[VBUS_BIT] | s.en_fall[VBUS_BIT]; // see RULE_01
  assign vbus_gated = vbus_valid_cmp_i & cmp_en; // see RULE_01

  // The selector sees the gated level, so a disabled comparator is also reported low except when pass-through fixes the report high
  vmc_vbus_select u_sel (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .use_ext_i (s.ext_cfg[EXT_USE_BIT]),
    .pass_i    (s.ext_cfg[EXT_PASS_BIT]),
    .compl_i   (s.ext_cfg[EXT_COMPL_BIT]),
    .cmp_i     (vbus_gated),
    .sel_o     (sel_vbus),
    .changed_o (sel_changed)
  );

  always_comb begin
    logic [IRQ_W-1:0]  irq_set;
    logic [IRQ_W-1:0]  irq_clr;
    logic [DATA_W-1:0] rd;
    irq_set = '0;
    irq_clr = '0;
    rd      = '0;
    s_nxt   = s;

    // Write channel: address and data may arrive in either order
    if (aw_fire) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr  = s_axi_awaddr_i;
    end
    if (w_fire) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata  = s_axi_wdata_i;
      s_nxt.wstrb  = s_axi_wstrb_i;
    end
    if (do_wr) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = is_mapped(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
      // Every field sits in the low byte, so only lane 0 matters
      if (s.wstrb[0]) begin
        case (s.awaddr)
          OFF_OTG_CTRL: s_nxt.otg_ctrl = s.wdata[REG_W-1:0];
          OFF_EN_RISE:  s_nxt.en_rise  = s.wdata[REG_W-1:0];
          OFF_EN_FALL:  s_nxt.en_fall  = s.wdata[REG_W-1:0];
          OFF_EXT_CFG:  s_nxt.ext_cfg  = s.wdata[REG_W-1:0];
          OFF_IO_PWR:   s_nxt.io_pwr   = s.wdata[REG_W-1:0];
          OFF_IRQ_STAT: irq_clr        = s.wdata[IRQ_W-1:0];
          OFF_IRQ_MASK: s_nxt.irq_mask = s.wdata[REG_W-1:0];
          default:      irq_clr        = '0;
        endcase
      end
    end
    if (s.bvalid && s_axi_bready_i) begin
      s_nxt.bvalid = 1'b0;
    end
    s_nxt.awready = ~s_nxt.aw_held & ~s_nxt.bvalid;
    s_nxt.wready  = ~s_nxt.w_held & ~s_nxt.bvalid;

    // Read channel: one outstanding read, data one cycle after the address
    if (ar_fire) begin
      case (s_axi_araddr_i)
        OFF_OTG_CTRL: rd[REG_W-1:0] = s.otg_ctrl;
        OFF_EN_RISE:  rd[REG_W-1:0] = s.en_rise;
        OFF_EN_FALL:  rd[REG_W-1:0] = s.en_fall;
        OFF_INT_STAT: begin
          rd[VBUS_BIT] = vbus_gated; // see RULE_01
          rd[SESS_BIT] = session_valid_cmp_i; // see RULE_13
        end
        OFF_EXT_CFG:  rd[REG_W-1:0] = s.ext_cfg;
        OFF_IO_PWR:   rd[REG_W-1:0] = s.io_pwr;
        OFF_IRQ_STAT: rd[IRQ_W-1:0] = s.irq_stat;
        OFF_IRQ_MASK: rd[REG_W-1:0] = s.irq_mask;
        default:      rd            = '0;
      endcase
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd;
      s_nxt.rresp  = is_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rvalid && s_axi_rready_i) begin
      s_nxt.rvalid = 1'b0;
    end
    s_nxt.arready = ~s_nxt.rvalid;

    // Edge events; session-valid enables gate only its interrupts
    s_nxt.vbus_prev = vbus_gated;
    s_nxt.sess_prev = session_valid_cmp_i;
    irq_set[IRQ_VBUS_RISE] = vbus_gated & ~s.vbus_prev & s.en_rise[VBUS_BIT];
    irq_set[IRQ_VBUS_FALL] = ~vbus_gated & s.vbus_prev & s.en_fall[VBUS_BIT];
    irq_set[IRQ_SESS_RISE] = session_valid_cmp_i & ~s.sess_prev & s.en_rise[SESS_BIT]; // see RULE_13
    irq_set[IRQ_SESS_FALL] = ~session_valid_cmp_i & s.sess_prev & s.en_fall[SESS_BIT]; // see RULE_13
    // A new event beats a simultaneous write-one-to-clear
    s_nxt.irq_stat = (s.irq_stat & ~irq_clr) | irq_set;
    s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask[IRQ_W-1:0]);

    // Receive command report: held until the ULPI side takes it
    // A change in the acknowledge cycle keeps the report pending, so none is lost
    s_nxt.rxcmd_vbus = sel_vbus; // see RULE_14
    if (sel_changed) begin
      s_nxt.rxcmd_pend = 1'b1; // see RULE_14
    end else if (rxcmd_ack_i) begin
      s_nxt.rxcmd_pend = 1'b0;
    end

    // Analogue controls
    s_nxt.cmp_en    = cmp_en;
    s_nxt.discharge = s.otg_ctrl[DISCHARGE_BIT]; // see RULE_08
    s_nxt.charge    = s.otg_ctrl[CHARGE_BIT]; // see RULE_09
    s_nxt.dp_pu     = chip_reset_n_i & s.io_pwr[DP_PU_BIT]; // see RULE_12
    s_nxt.dm_pu     = chip_reset_n_i & s.io_pwr[DM_PU_BIT]; // see RULE_12
    if (s.io_pwr[UART_MODE_BIT]) begin
      s_nxt.reg_level = s.io_pwr[UART_LVL_HI:UART_LVL_LO]; // see RULE_10
      s_nxt.data_lo   = 2'h0; // see RULE_11
    end else begin
      s_nxt.reg_level = s.io_pwr[NORM_LVL_HI:NORM_LVL_LO];
      s_nxt.data_lo   = linestate_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    // Readies stand high in reset so the first request after release is taken at once
    if (!rst_n_i) begin
      s          <= '0;
      s.awready  <= 1'b1;
      s.wready   <= 1'b1;
      s.arready  <= 1'b1;
      s.otg_ctrl <= RST_OTG_CTRL;
      s.en_rise  <= RST_INT_EN;
      s.en_fall  <= RST_INT_EN;
      s.ext_cfg  <= RST_EXT_CFG; // see RULE_03
      s.io_pwr   <= RST_IO_PWR;
      s.irq_mask <= RST_IRQ_MASK;
    end else begin
      s <= s_nxt;
    end
  end

  assign s_axi_awready_o      = s.awready;
  assign s_axi_wready_o       = s.wready;
  assign s_axi_bresp_o        = s.bresp;
  assign s_axi_bvalid_o       = s.bvalid;
  assign s_axi_arready_o      = s.arready;
  assign s_axi_rdata_o        = s.rdata;
  assign s_axi_rresp_o        = s.rresp;
  assign s_axi_rvalid_o       = s.rvalid;
  assign vbus_cmp_en_o        = s.cmp_en;
  assign vbus_discharge_ctl_o = s.discharge;
  assign vbus_charge_ctl_o    = s.charge;
  assign dp_detect_pullup_o   = s.dp_pu;
  assign dm_detect_pullup_o   = s.dm_pu;
  assign regulator_level_o    = s.reg_level;
  assign ulpi_data_lo_o       = s.data_lo;
  assign rxcmd_vbus_valid_o   = s.rxcmd_vbus;
  assign rxcmd_req_o          = s.rxcmd_pend;
  assign irq_o                = s.irq;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence status_read;
    ar_fire && s_axi_araddr_i == OFF_INT_STAT;
  endsequence

  sequence ctrl_write;
    do_wr && s.awaddr == OFF_OTG_CTRL && s.wstrb[0];
  endsequence

  sequence vbus_rise_seen;
    vbus_gated && !s.vbus_prev;
  endsequence

  sequence sess_fall_seen;
    !session_valid_cmp_i && s.sess_prev;
  endsequence

  vbus_off_zero_a: assert property (status_read and (!cmp_en) |=> !s_axi_rdata_o[VBUS_BIT]) // see RULE_01
    else $error("disabled comparator read as set");
  cmp_enable_out_a: assert property (!cmp_en [*2] |-> !vbus_cmp_en_o) // see RULE_01
    else $error("comparator enable stays on");
  ext_off_reset_a: assert property (!$past(rst_n_i) |-> !s.ext_cfg[EXT_USE_BIT] && !s.ext_cfg[EXT_PASS_BIT]) // see RULE_03
    else $error("external indicator path on after reset");
  discharge_ctl_a: assert property (ctrl_write |-> ##2 vbus_discharge_ctl_o == $past(s.wdata[DISCHARGE_BIT], 2)) // see RULE_08
    else $error("discharge control not taken from bit 3");
  charge_ctl_a: assert property (ctrl_write |-> ##2 vbus_charge_ctl_o == $past(s.wdata[CHARGE_BIT], 2)) // see RULE_09
    else $error("charge control not taken from bit 4");
  uart_regulator_a: assert property (s.io_pwr[UART_MODE_BIT] |=> // see RULE_10
    regulator_level_o == $past(s.io_pwr[UART_LVL_HI:UART_LVL_LO]))
    else $error("regulator level wrong in UART mode");
  uart_linestate_a: assert property (s.io_pwr[UART_MODE_BIT] |=> ulpi_data_lo_o == 2'h0) // see RULE_11
    else $error("line state shown in UART mode");
  pullup_reset_a: assert property (!chip_reset_n_i |=> !dp_detect_pullup_o && !dm_detect_pullup_o) // see RULE_12
    else $error("detection pull-up on during chip reset");
  pullup_follow_a: assert property (chip_reset_n_i |=> dp_detect_pullup_o == $past(s.io_pwr[DP_PU_BIT])) // see RULE_12
    else $error("dp pull-up does not follow its enable");
  sess_readable_a: assert property (status_read |=> s_axi_rdata_o[SESS_BIT] == $past(session_valid_cmp_i)) // see RULE_13
    else $error("session state not readable");
  rxcmd_report_a: assert property (sel_changed |=> rxcmd_req_o && rxcmd_vbus_valid_o == $past(sel_vbus)) // see RULE_14
    else $error("source change not reported");
  rxcmd_hold_a: assert property (rxcmd_req_o && !rxcmd_ack_i |=> rxcmd_req_o) // see RULE_14
    else $error("report dropped before acknowledge");
  irq_level_a: assert property (irq_o == |(s.irq_stat & s.irq_mask[IRQ_W-1:0]))
    else $error("interrupt level does not match unmasked status");
  write_resp_a: assert property (do_wr |=> s_axi_bvalid_o && !s_axi_awready_o)
    else $error("write response missing");
  read_answer_a: assert property (ar_fire |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read data missing");
  bresp_map_a: assert property (do_wr && !is_mapped(s.awaddr) |=> s_axi_bresp_o == RESP_SLVERR)
    else $error("unmapped write not refused");
  rresp_map_a: assert property (ar_fire && !is_mapped(s_axi_araddr_i) |=>
    s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == '0)
    else $error("unmapped read not refused");
  cmp_on_a: assert property (cmp_en |=> vbus_cmp_en_o) // see RULE_01
    else $error("comparator enable not raised");
  pullup_dm_a: assert property (chip_reset_n_i |=> dm_detect_pullup_o == $past(s.io_pwr[DM_PU_BIT])) // see RULE_12
    else $error("dm pull-up does not follow its enable");
  linestate_pass_a: assert property (!s.io_pwr[UART_MODE_BIT] |=> ulpi_data_lo_o == $past(linestate_i))
    else $error("line state not passed outside UART mode");
  pend_clear_a: assert property (rxcmd_req_o && rxcmd_ack_i && !sel_changed |=> !rxcmd_req_o) // see RULE_14
    else $error("report still pending after acknowledge");
  vbus_rise_set_a: assert property (vbus_rise_seen and (s.en_rise[VBUS_BIT]) |=> s.irq_stat[IRQ_VBUS_RISE])
    else $error("vbus rise event not recorded");
  sess_irq_gate_a: assert property (sess_fall_seen and (!s.en_fall[SESS_BIT]) and // see RULE_13
    (!s.irq_stat[IRQ_SESS_FALL]) |=> !s.irq_stat[IRQ_SESS_FALL])
    else $error("disabled session event recorded");

endmodule : vmc_vbus_monitor

// *** testbench/vmc_link_model.sv ***
`timescale 1ns/10ps
module vmc_link_model (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // Receive command handshake
  input  wire logic       rxcmd_req_i,
  input  wire logic [3:0] ack_delay_i,
  output logic            rxcmd_ack_o,
  output logic [7:0]      ack_cnt_o
);
  logic [3:0] wait_r;

  // Reports are only acknowledged; nothing is started from VBUS-valid
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rxcmd_ack_o <= 1'b0;
      ack_cnt_o   <= 8'h00;
      wait_r      <= 4'h0;
    end else if (rxcmd_ack_o) begin
      // Drop after one cycle so a held request is never taken twice
      rxcmd_ack_o <= 1'b0;
      wait_r      <= 4'h0;
    end else if (rxcmd_req_i) begin
      if (wait_r >= ack_delay_i) begin
        rxcmd_ack_o <= 1'b1;
        ack_cnt_o   <= ack_cnt_o + 8'h01;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule : vmc_link_model

// *** testbench/tb_vmc_vbus_monitor.sv ***
`timescale 1ns/10ps
module tb_vmc_vbus_monitor
  import vmc_pkg::*;
;
  logic        mclk = 1'b0, rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, ulpi_lo, reg_lvl;
  logic        vcmp = 1'b0, scmp = 1'b0, chip_rst_n = 1'b1;
  logic [1:0]  lstate = 2'b00;
  logic        cmp_en, dis_ctl, chg_ctl, dp_pu, dm_pu, rx_vbus, rx_req, rx_ack, irq;
  logic [3:0]  ack_delay = 4'h6;
  logic [7:0]  ack_cnt;
  int          error_cnt = 0;
  int          cmp_count = 0;
  logic [7:0]  offs [6] = '{OFF_OTG_CTRL, OFF_EN_RISE, OFF_EN_FALL, OFF_EXT_CFG, OFF_IO_PWR, OFF_IRQ_MASK};
  logic [7:0]  rstv [6] = '{RST_OTG_CTRL, RST_INT_EN, RST_INT_EN, RST_EXT_CFG, RST_IO_PWR, RST_IRQ_MASK};

  always #12.5 mclk = ~mclk;

  vmc_vbus_monitor u_dut (
    .mclk_i(mclk), .rst_n_i(rst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .vbus_valid_cmp_i(vcmp), .session_valid_cmp_i(scmp), .chip_reset_n_i(chip_rst_n), .linestate_i(lstate),
    .vbus_cmp_en_o(cmp_en), .vbus_discharge_ctl_o(dis_ctl), .vbus_charge_ctl_o(chg_ctl),
    .dp_detect_pullup_o(dp_pu), .dm_detect_pullup_o(dm_pu), .regulator_level_o(reg_lvl),
    .ulpi_data_lo_o(ulpi_lo), .rxcmd_vbus_valid_o(rx_vbus), .rxcmd_req_o(rx_req), .rxcmd_ack_i(rx_ack),
    .irq_o(irq)
  );

  vmc_link_model u_link (
    .mclk_i(mclk), .rst_n_i(rst_n), .rxcmd_req_i(rx_req), .ack_delay_i(ack_delay),
    .rxcmd_ack_o(rx_ack), .ack_cnt_o(ack_cnt)
  );

  task automatic final_report();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chkb

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  // Address and data are offered together and each is released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic aw_d;
    logic w_d;
    n = 0;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge mclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (n < 64) begin
      @(posedge mclk);
      n++;
      if (!aw_d && awready) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk({29'h0, n < 64, bresp}, {29'h1, er});
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int   n;
    logic ar_d;
    n = 0;
    ar_d = 1'b0;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (n < 64) begin
      @(posedge mclk);
      n++;
      if (!ar_d && arready) begin
        ar_d = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk({29'h0, n < 64, rresp}, {29'h1, er});
    chk(rdata, ed);
  endtask : rdc

  function automatic logic ext_exp(input logic v, input logic [2:0] c);
    return c[0] ? (c[2] ? 1'b0 : (c[1] ? 1'b1 : v)) : v;
  endfunction : ext_exp

  initial begin
    // Sized from under four hundred cycles of traffic, with ample margin
    #(25 * 20000);
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rdc(offs[i], {24'h0, rstv[i]}, RESP_OKAY);
    rdc(8'h20, 32'h0000_0000, RESP_SLVERR);
    wr(8'h20, 32'h0000_00FF, RESP_SLVERR);
    chkb(cmp_en, 1'b1);
    wr(OFF_IRQ_MASK, 32'h0000_0001, RESP_OKAY);
    @(posedge mclk);
    vcmp <= 1'b1;
    cyc(5);
    chkb(rx_req, 1'b1);
    chkb(rx_vbus, 1'b1);
    chkb(irq, 1'b1);
    rdc(OFF_IRQ_STAT, 32'h0000_0001, RESP_OKAY);
    cyc(10);
    chkb(rx_req, 1'b0);
    chk({24'h0, ack_cnt}, 32'h0000_0001);
    wr(OFF_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    cyc(2);
    chkb(irq, 1'b0);
    wr(OFF_IRQ_STAT, 32'h0000_0001, RESP_OKAY);
    rdc(OFF_IRQ_STAT, 32'h0000_0000, RESP_OKAY);
    @(posedge mclk);
    scmp <= 1'b1;
    cyc(3);
    rdc(OFF_IRQ_STAT, 32'h0000_0004, RESP_OKAY);
    rdc(OFF_INT_STAT, 32'h0000_0006, RESP_OKAY);
    wr(OFF_EN_RISE, 32'h0000_0004, RESP_OKAY);
    cyc(2);
    chkb(cmp_en, 1'b1);
    wr(OFF_EN_FALL, 32'h0000_0004, RESP_OKAY);
    cyc(2);
    chkb(cmp_en, 1'b0);
    rdc(OFF_INT_STAT, 32'h0000_0004, RESP_OKAY);
    wr(OFF_EN_RISE, 32'h0000_0000, RESP_OKAY);
    wr(OFF_EN_FALL, 32'h0000_0000, RESP_OKAY);
    rdc(OFF_INT_STAT, 32'h0000_0004, RESP_OKAY);
    @(posedge mclk);
    scmp <= 1'b0;
    cyc(2);
    rdc(OFF_INT_STAT, 32'h0000_0000, RESP_OKAY);
    rdc(OFF_IRQ_STAT, 32'h0000_0004, RESP_OKAY);
    wr(OFF_EN_RISE, 32'h0000_0006, RESP_OKAY);
    wr(OFF_EN_FALL, 32'h0000_0006, RESP_OKAY);
    ack_delay <= 4'h0;
    for (int v = 0; v < 2; v++) begin
      @(posedge mclk);
      vcmp <= v[0];
      for (int c = 0; c < 8; c++) begin
        wr(OFF_EXT_CFG, 32'(c), RESP_OKAY);
        cyc(6);
        chkb(rx_vbus, ext_exp(v[0], c[2:0]));
      end
    end
    for (int k = 0; k < 4; k++) begin
      wr(OFF_OTG_CTRL, 32'(k << 3), RESP_OKAY);
      cyc(2);
      chkb(dis_ctl, k[0]);
      chkb(chg_ctl, k[1]);
    end
    lstate <= 2'b10;
    wr(OFF_IO_PWR, 32'h0000_0048, RESP_OKAY);
    cyc(2);
    chk(32'(reg_lvl), 32'h0000_0002);
    chk(32'(ulpi_lo), 32'h0000_0002);
    wr(OFF_IO_PWR, 32'h0000_0049, RESP_OKAY);
    cyc(2);
    chk(32'(reg_lvl), 32'h0000_0001);
    chk(32'(ulpi_lo), 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_IO_PWR, 32'(k << 1), RESP_OKAY);
      for (int r = 0; r < 2; r++) begin
        @(posedge mclk);
        chip_rst_n <= r[0];
        cyc(3);
        chkb(dp_pu, r[0] & k[0]);
        chkb(dm_pu, r[0] & k[1]);
      end
    end
    final_report();
  end
endmodule : tb_vmc_vbus_monitor
